/* File: inc/omc_pkg.sv */
package omc_pkg;

    // Clock rate and the cycle counts derived from it.
    localparam int CLK_HZ = 100_000_000;
    localparam int CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1_000;

    // Timing figures in their own units.
    localparam int T_RESET_US = 10;
    localparam int T_SERIAL_MS = 300;
    localparam int T_WRITE_MS = 10;
    localparam int T_ON_MS = 1;
    localparam int T_FAULT_US = 100;

    // Least hold time of the disable pin that clears a latched fault.
    localparam int T_RESET_CYC = T_RESET_US * CYC_PER_US;
    // Longest times; the design uses them exactly as its bus-ready and write-busy delays.
    localparam int T_SERIAL_CYC = T_SERIAL_MS * CYC_PER_MS;
    localparam int T_WRITE_CYC = T_WRITE_MS * CYC_PER_MS;

    // Two-wire bus device addresses (7-bit) and the control byte.
    localparam logic [6:0] DEV_ADDR_ID = 7'h50;
    localparam logic [6:0] DEV_ADDR_DIAG = 7'h51;
    localparam logic [7:0] CTRL_STATUS_OFS = 8'h6e;
    localparam logic [7:0] CTRL_STATUS_RST = 8'h00;

    // Field positions in the control/status byte.
    localparam int BIT_HW_DISABLE = 7;
    localparam int BIT_SOFT_DISABLE = 6;
    localparam int BIT_TX_FAULT = 2;
    localparam int BIT_RX_LOST = 1;
    localparam int BIT_DATA_READY = 0;

    // Synchronised input vector layout.
    localparam int SYN_W = 5;
    localparam int SYN_SCL = 0;
    localparam int SYN_SDA = 1;
    localparam int SYN_TXDIS = 2;
    localparam int SYN_FAULT = 3;
    localparam int SYN_SIGDET = 4;

    typedef enum logic [8:0] {
        ST_IDLE      = 9'h001,
        ST_ADDR      = 9'h002,
        ST_ADDR_ACK  = 9'h004,
        ST_WADDR     = 9'h008,
        ST_WADDR_ACK = 9'h010,
        ST_WDATA     = 9'h020,
        ST_WDATA_ACK = 9'h040,
        ST_RDATA     = 9'h080,
        ST_RDATA_ACK = 9'h100
    } omc_state_t;

endpackage : omc_pkg

/* File: rtl/omc_sync.sv */
`timescale 1ns/1ps
// Three-stage synchroniser; the output follows only when stages two and three agree.
module omc_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Asynchronous inputs and filtered outputs
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    for (genvar g = 0; g < WIDTH; g++) begin : g_bit
        logic s1_q, s2_q, s3_q, out_q;
        logic out_d;

        always_comb begin
            out_d = (s2_q == s3_q) ? s3_q : out_q;
        end

        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                s1_q <= 1'b0;
                s2_q <= 1'b0;
                s3_q <= 1'b0;
                out_q <= 1'b0;
            end else begin
                s1_q <= async_i[g];
                s2_q <= s1_q;
                s3_q <= s2_q;
                out_q <= out_d;
            end
        end

        assign sync_o[g] = out_q;
    end
endmodule : omc_sync

/* File: rtl/omc_ctrl.sv */
`timescale 1ns/1ps
module omc_ctrl
    import omc_pkg::*;
#(
    parameter int SERIAL_READY_CYC = T_SERIAL_CYC,
    parameter int WRITE_BUSY_CYC = T_WRITE_CYC,
    parameter bit DIAG_MONITOR_OPTION = 1'b1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Module pins
    input wire logic tx_disable_i,
    output logic tx_fault_o,
    output logic receive_signal_lost_o,
    // Laser driver and receiver
    input wire logic laser_fault_i,
    input wire logic signal_detect_i,
    output logic laser_enable_o,
    // Two-wire management bus
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o
);
    logic [SYN_W-1:0] syn;
    logic scl, sda, hw_dis, fault_in, sig_det;

    omc_sync #(.WIDTH(SYN_W)) u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        // The bus lines idle high; passing them inverted makes the synchroniser's reset
        // value match that idle level, so no false bus edge follows reset.
        .async_i({signal_detect_i, laser_fault_i, tx_disable_i, ~sda_i, ~scl_i}),
        .sync_o(syn)
    );

    assign scl = !syn[SYN_SCL];
    assign sda = !syn[SYN_SDA];
    assign hw_dis = syn[SYN_TXDIS];
    assign fault_in = syn[SYN_FAULT];
    assign sig_det = syn[SYN_SIGDET];

    // Power-on, fault and laser state.
    logic [31:0] por_cnt_q, por_cnt_d;
    logic [31:0] hold_cnt_q, hold_cnt_d;
    logic [31:0] busy_cnt_q, busy_cnt_d;
    logic bus_ready_q, bus_ready_d;
    logic fault_q, fault_d;
    logic laser_en_q, laser_en_d;
    logic los_q, los_d;
    logic soft_dis_q, soft_dis_d;
    logic fault_clear;
    logic apply_write;

    always_comb begin
        por_cnt_d = por_cnt_q;
        bus_ready_d = bus_ready_q;
        if (!bus_ready_q) begin
            por_cnt_d = por_cnt_q + 32'h1;
            bus_ready_d = (por_cnt_q >= 32'(SERIAL_READY_CYC - 1));
        end
        // The pin must stay high a full hold time before the latch may clear.
        hold_cnt_d = hw_dis ? hold_cnt_q : 32'h0;
        if (hw_dis && hold_cnt_q < 32'(T_RESET_CYC)) begin
            hold_cnt_d = hold_cnt_q + 32'h1;
        end
        fault_clear = hw_dis && (hold_cnt_q >= 32'(T_RESET_CYC));
        // A fault still present during the clear wins, so it is reported again.
        fault_d = fault_in ? 1'b1 : (fault_clear ? 1'b0 : fault_q);
        laser_en_d = !hw_dis && !soft_dis_q && !fault_d;
        los_d = !sig_det;
        busy_cnt_d = (busy_cnt_q != 32'h0) ? busy_cnt_q - 32'h1 : 32'h0;
        if (apply_write) begin
            busy_cnt_d = 32'(WRITE_BUSY_CYC);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            por_cnt_q <= 32'h0;
            bus_ready_q <= 1'b0;
            hold_cnt_q <= 32'h0;
            fault_q <= 1'b0;
            laser_en_q <= 1'b0;
            los_q <= 1'b1;
            busy_cnt_q <= 32'h0;
        end else begin
            por_cnt_q <= por_cnt_d;
            bus_ready_q <= bus_ready_d;
            hold_cnt_q <= hold_cnt_d;
            fault_q <= fault_d;
            laser_en_q <= laser_en_d;
            los_q <= los_d;
            busy_cnt_q <= busy_cnt_d;
        end
    end

    assign tx_fault_o = fault_q;
    assign receive_signal_lost_o = los_q;
    assign laser_enable_o = laser_en_q;

    // Control/status byte as seen by the host.
    logic [7:0] ctrl_status;
    always_comb begin
        ctrl_status = CTRL_STATUS_RST;
        ctrl_status[BIT_HW_DISABLE] = hw_dis;
        ctrl_status[BIT_SOFT_DISABLE] = soft_dis_q;
        ctrl_status[BIT_TX_FAULT] = fault_q;
        ctrl_status[BIT_RX_LOST] = los_q;
        ctrl_status[BIT_DATA_READY] = bus_ready_q && DIAG_MONITOR_OPTION;
    end

    // Two-wire slave.
    omc_state_t state_q, state_d;
    logic scl_prev_q, sda_prev_q;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] shift_q, shift_d;
    logic [7:0] ptr_q, ptr_d;
    logic diag_q, diag_d;
    logic rw_q, rw_d;
    logic drv_q, drv_d;
    logic wr_seen_q, wr_seen_d;
    logic soft_pend_q, soft_pend_d;
    logic scl_rise, scl_fall, start_c, stop_c, addr_hit;
    logic [7:0] rd_byte;

    always_comb begin
        scl_rise = scl && !scl_prev_q;
        scl_fall = !scl && scl_prev_q;
        start_c = scl && scl_prev_q && sda_prev_q && !sda;
        stop_c = scl && scl_prev_q && !sda_prev_q && sda;
        // Reads at the pointer plus one serve the byte after an acknowledged read.
        rd_byte = (diag_q && 8'(ptr_q + 8'h1) == CTRL_STATUS_OFS) ? ctrl_status : 8'h00;
        addr_hit = bus_ready_q && (busy_cnt_q == 32'h0) &&
            (shift_q[7:1] == DEV_ADDR_ID || shift_q[7:1] == DEV_ADDR_DIAG);
        state_d = state_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        ptr_d = ptr_q;
        diag_d = diag_q;
        rw_d = rw_q;
        drv_d = drv_q;
        wr_seen_d = wr_seen_q;
        soft_pend_d = soft_pend_q;
        apply_write = 1'b0;
        soft_dis_d = soft_dis_q;
        if (start_c) begin
            state_d = ST_ADDR;
            cnt_d = 4'h0;
            drv_d = 1'b0;
        end else if (stop_c) begin
            state_d = ST_IDLE;
            drv_d = 1'b0;
            if (wr_seen_q) begin
                apply_write = 1'b1;
                soft_dis_d = soft_pend_q;
                wr_seen_d = 1'b0;
            end
        end else if (scl_rise) begin
            unique case (state_q)
                ST_ADDR, ST_WADDR, ST_WDATA: begin
                    shift_d = {shift_q[6:0], sda};
                    cnt_d = cnt_q + 4'h1;
                end
                ST_RDATA: cnt_d = cnt_q + 4'h1;
                ST_RDATA_ACK: if (sda) state_d = ST_IDLE;
                ST_IDLE, ST_ADDR_ACK, ST_WADDR_ACK, ST_WDATA_ACK: ;
            endcase
        end else if (scl_fall) begin
            unique case (state_q)
                ST_ADDR: if (cnt_q == 4'h8) begin
                    state_d = addr_hit ? ST_ADDR_ACK : ST_IDLE;
                    drv_d = addr_hit;
                    diag_d = shift_q[1];
                    rw_d = shift_q[0];
                end
                ST_ADDR_ACK: begin
                    cnt_d = 4'h0;
                    if (rw_q) begin
                        shift_d = (diag_q && ptr_q == CTRL_STATUS_OFS) ? ctrl_status : 8'h00;
                        drv_d = !shift_d[7];
                        state_d = ST_RDATA;
                    end else begin
                        drv_d = 1'b0;
                        state_d = ST_WADDR;
                    end
                end
                ST_WADDR: if (cnt_q == 4'h8) begin
                    ptr_d = shift_q;
                    drv_d = 1'b1;
                    state_d = ST_WADDR_ACK;
                end
                ST_WDATA: if (cnt_q == 4'h8) begin
                    if (diag_q && ptr_q == CTRL_STATUS_OFS) begin
                        soft_pend_d = shift_q[BIT_SOFT_DISABLE];
                    end
                    wr_seen_d = 1'b1;
                    ptr_d = ptr_q + 8'h1;
                    drv_d = 1'b1;
                    state_d = ST_WDATA_ACK;
                end
                ST_WADDR_ACK, ST_WDATA_ACK: begin
                    soft_pend_d = (state_q == ST_WADDR_ACK) ? soft_dis_q : soft_pend_q;
                    cnt_d = 4'h0;
                    drv_d = 1'b0;
                    state_d = ST_WDATA;
                end
                ST_RDATA: if (cnt_q == 4'h8) begin
                    drv_d = 1'b0;
                    state_d = ST_RDATA_ACK;
                end else begin
                    drv_d = !shift_q[3'(4'h7 - cnt_q)];
                end
                ST_RDATA_ACK: begin
                    ptr_d = ptr_q + 8'h1;
                    shift_d = rd_byte;
                    cnt_d = 4'h0;
                    drv_d = !rd_byte[7];
                    state_d = ST_RDATA;
                end
                ST_IDLE: ;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            cnt_q <= 4'h0;
            shift_q <= 8'h00;
            ptr_q <= 8'h00;
            diag_q <= 1'b0;
            rw_q <= 1'b0;
            drv_q <= 1'b0;
            wr_seen_q <= 1'b0;
            soft_pend_q <= 1'b0;
            soft_dis_q <= 1'b0;
        end else begin
            state_q <= state_d;
            scl_prev_q <= scl;
            sda_prev_q <= sda;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            ptr_q <= ptr_d;
            diag_q <= diag_d;
            rw_q <= rw_d;
            drv_q <= drv_d;
            wr_seen_q <= wr_seen_d;
            soft_pend_q <= soft_pend_d;
            soft_dis_q <= soft_dis_d;
        end
    end

    // Open drain: the module only ever pulls the line low.
    assign sda_o = 1'b0;
    assign sda_oe_n_o = !drv_q;

endmodule : omc_ctrl

/* File: dv/omc_ctrl_assertions.sv */
`timescale 1ns/1ps
module omc_ctrl_chk (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Pins watched
    input wire logic tx_disable_i,
    input wire logic laser_fault_i,
    input wire logic signal_detect_i,
    input wire logic tx_fault_o,
    input wire logic receive_signal_lost_o,
    input wire logic laser_enable_o,
    input wire logic sda_oe_n_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // Cycles since reset release, saturating so it never wraps back to the checked value.
    logic [7:0] post_q;
    logic [7:0] post_d;
    always_comb begin
        post_d = (post_q == 8'hff) ? post_q : post_q + 8'h01;
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            post_q <= 8'h00;
        end else begin
            post_q <= post_d;
        end
    end

    property p_hw_off;
        $rose(tx_disable_i) |-> ##[1:7] !laser_enable_o;
    endproperty
    a_hw_off: assert property (p_hw_off) else $error("laser still on after disable pin");
    property p_hw_hold;
        tx_disable_i [*8] |-> !laser_enable_o;
    endproperty
    a_hw_hold: assert property (p_hw_hold) else $error("laser on while pin held");
    property p_power_on;
        (post_q == 8'd20) && !tx_disable_i && !laser_fault_i |-> laser_enable_o;
    endproperty
    a_power_on: assert property (p_power_on) else $error("laser not on after reset");
    property p_fault_set;
        laser_fault_i [*8] |-> tx_fault_o;
    endproperty
    a_fault_set: assert property (p_fault_set) else $error("fault output late");
    property p_fault_off;
        tx_fault_o [*2] |-> !laser_enable_o;
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("laser on with fault latched");
    property p_fault_clear;
        $fell(tx_fault_o) |-> $past(tx_disable_i, 8);
    endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("fault cleared without pin");
    property p_los_on;
        !signal_detect_i [*8] |-> receive_signal_lost_o;
    endproperty
    a_los_on: assert property (p_los_on) else $error("signal lost output late");
    property p_los_off;
        signal_detect_i [*8] |-> !receive_signal_lost_o;
    endproperty
    a_los_off: assert property (p_los_off) else $error("signal lost output stuck");

    c_fault_clear: cover property ($fell(tx_fault_o));
    c_ack: cover property ($fell(sda_oe_n_o));
    c_los: cover property ($rose(receive_signal_lost_o));
endmodule : omc_ctrl_chk

bind omc_ctrl omc_ctrl_chk i_chk (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .tx_disable_i(tx_disable_i),
    .laser_fault_i(laser_fault_i),
    .signal_detect_i(signal_detect_i),
    .tx_fault_o(tx_fault_o),
    .receive_signal_lost_o(receive_signal_lost_o),
    .laser_enable_o(laser_enable_o),
    .sda_oe_n_o(sda_oe_n_o)
);

/* File: dv/omc_host_model.sv */
`timescale 1ns/1ps
module omc_host_model
    import omc_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Two-wire bus
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    // The bus clock stands high between frames and the data line is released.
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // One quarter of the bus clock period; the bench runs the bus far faster than a real
    // host may, to keep runs short.
    task automatic q;
        repeat (4) @(negedge clk_i);
    endtask : q
    task automatic start;
        sda_low_o = 1'b0;
        q;
        scl_o = 1'b1;
        q;
        sda_low_o = 1'b1;
        q;
        scl_o = 1'b0;
        q;
    endtask : start
    task automatic stop;
        sda_low_o = 1'b1;
        q;
        scl_o = 1'b1;
        q;
        sda_low_o = 1'b0;
        q;
    endtask : stop
    // Data changes only while the bus clock is low, a quarter period away from its edges.
    task automatic xfer(input logic [7:0] d, input logic m_ack, output logic [7:0] r,
                        output logic ack);
        for (int i = 7; i >= -1; i--) begin
            sda_low_o = (i < 0) ? m_ack : ~d[i];
            q;
            scl_o = 1'b1;
            q;
            if (i < 0) ack = ~sda_i;
            else r[i] = sda_i;
            q;
            scl_o = 1'b0;
            q;
        end
    endtask : xfer
    task automatic wr(input logic [6:0] dev, input logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic a0;
        logic a1;
        logic a2;
        start;
        xfer({dev, 1'b0}, 1'b0, r, a0);
        xfer(CTRL_STATUS_OFS, 1'b0, r, a1);
        xfer(d, 1'b0, r, a2);
        stop;
        ok = a0 & a1 & a2;
    endtask : wr
    // A single-byte read ends with the host leaving the data line released.
    task automatic rd(input logic [6:0] dev, output logic [7:0] v, output logic ok);
        logic [7:0] r;
        logic a0;
        logic a1;
        logic a2;
        start;
        xfer({dev, 1'b0}, 1'b0, r, a0);
        xfer(CTRL_STATUS_OFS, 1'b0, r, a1);
        start;
        xfer({dev, 1'b1}, 1'b0, r, a2);
        xfer(8'hff, 1'b0, v, a0);
        stop;
        ok = a1 & a2;
    endtask : rd
endmodule : omc_host_model

/* File: dv/omc_ctrl_tb.sv */
`timescale 1ns/1ps
module omc_ctrl_tb;
    import omc_pkg::*;
    localparam int READY_CYC = 400;
    localparam int BUSY_CYC = 400;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic tx_disable_i = 1'b0;
    logic laser_fault_i = 1'b0;
    logic signal_detect_i = 1'b1;
    logic tx_fault_o;
    logic receive_signal_lost_o;
    logic laser_enable_o;
    logic sda_oe_n_o;
    logic scl;
    logic host_low;
    logic sda_w;
    logic [7:0] v;
    logic ok;
    int failures = 0;
    int comparisons = 0;
    always #5 clk_i = ~clk_i;
    // Open drain with a pull-up: low whenever either party pulls.
    assign sda_w = ~host_low & sda_oe_n_o;
    omc_ctrl #(.SERIAL_READY_CYC(READY_CYC), .WRITE_BUSY_CYC(BUSY_CYC)) i_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .tx_disable_i(tx_disable_i),
        .tx_fault_o(tx_fault_o), .receive_signal_lost_o(receive_signal_lost_o),
        .laser_fault_i(laser_fault_i), .signal_detect_i(signal_detect_i),
        .laser_enable_o(laser_enable_o), .scl_i(scl), .sda_i(sda_w), .sda_o(),
        .sda_oe_n_o(sda_oe_n_o));
    omc_host_model i_host (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_low_o(host_low));
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask : cyc
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic rd_chk(input logic [7:0] exp);
        i_host.rd(DEV_ADDR_DIAG, v, ok);
        chk({7'h00, ok}, 8'h01);
        chk(v, exp);
    endtask : rd_chk
    task automatic tally_and_finish;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (100000) @(posedge clk_i);
        failures++;
        tally_and_finish;
    end
    initial begin
        cyc(8);
        rst_n_i = 1'b1;
        i_host.wr(DEV_ADDR_DIAG, 8'h40, ok);
        chk({7'h00, ok}, 8'h00);
        cyc(READY_CYC);
        rd_chk(8'h01);
        chk({7'h00, laser_enable_o}, 8'h01);
        $display("test power-on done");
        i_host.wr(DEV_ADDR_DIAG, 8'h40, ok);
        chk({7'h00, ok}, 8'h01);
        cyc(8);
        chk({7'h00, laser_enable_o}, 8'h00);
        i_host.rd(DEV_ADDR_DIAG, v, ok);
        chk({7'h00, ok}, 8'h00);
        cyc(BUSY_CYC);
        rd_chk(8'h41);
        i_host.wr(DEV_ADDR_DIAG, 8'h00, ok);
        chk({7'h00, ok}, 8'h01);
        cyc(8);
        chk({7'h00, laser_enable_o}, 8'h01);
        cyc(BUSY_CYC);
        $display("test soft disable done");
        tx_disable_i = 1'b1;
        cyc(8);
        chk({7'h00, laser_enable_o}, 8'h00);
        rd_chk(8'h81);
        tx_disable_i = 1'b0;
        cyc(8);
        chk({7'h00, laser_enable_o}, 8'h01);
        $display("test pin disable done");
        laser_fault_i = 1'b1;
        cyc(8);
        chk({7'h00, tx_fault_o}, 8'h01);
        laser_fault_i = 1'b0;
        rd_chk(8'h05);
        tx_disable_i = 1'b1;
        cyc(T_RESET_CYC / 2);
        tx_disable_i = 1'b0;
        cyc(8);
        chk({7'h00, tx_fault_o}, 8'h01);
        tx_disable_i = 1'b1;
        cyc(T_RESET_CYC + 20);
        tx_disable_i = 1'b0;
        cyc(8);
        chk({7'h00, tx_fault_o}, 8'h00);
        chk({7'h00, laser_enable_o}, 8'h01);
        $display("test fault done");
        signal_detect_i = 1'b0;
        cyc(8);
        chk({7'h00, receive_signal_lost_o}, 8'h01);
        rd_chk(8'h03);
        signal_detect_i = 1'b1;
        cyc(8);
        chk({7'h00, receive_signal_lost_o}, 8'h00);
        rd_chk(8'h01);
        $display("test signal lost done");
        i_host.rd(DEV_ADDR_ID, v, ok);
        chk({7'h00, ok}, 8'h01);
        chk(v, 8'h00);
        i_host.rd(7'h52, v, ok);
        chk({7'h00, ok}, 8'h00);
        $display("test addresses done");
        tally_and_finish;
    end
endmodule : omc_ctrl_tb
